// ==== core/pixclk_pkg.sv ====
// shared constants and carrier types for the pixel clock and colour block
package pixclk_pkg;

  // colour mode field bit positions (field is four bits, bit 0 unused here)
  localparam int MODE_SEL_LO = 1;
  localparam int MODE_SEL_HI = 3;
  localparam logic [2:0] MODE_TRUE24 = 3'h7;
  // pseudo colour channel codes on field bits two and three
  localparam logic [1:0] PSEUDO_RED = 2'h0;
  localparam logic [1:0] PSEUDO_GREEN = 2'h1;
  localparam logic [1:0] PSEUDO_BLUE = 2'h2;

  // programmable clock divisor select codes
  localparam logic [1:0] DIV_4 = 2'h0;
  localparam logic [1:0] DIV_8 = 2'h1;
  localparam logic [1:0] DIV_16 = 2'h2;
  localparam logic [1:0] DIV_32 = 2'h3;

  // extra pipeline stages when latch timing is not met
  localparam int EXTRA_LAT_2TO1 = 2;
  localparam int EXTRA_LAT_1TO1 = 0;

  // table geometry
  localparam int LUT_DEPTH = 256;
  localparam int LUT_AW = 8;
  localparam int COMP_W = 10;
  localparam int FIFO_DEPTH = 8;

  // reset values
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [4:0] PRG_CNT_RESET = 5'h00;

  // one pixel as latched from the pixel port
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic blank_n;
    logic sync_n;
    logic [1:0] psel;
  } pixel_word_t;

  // one pixel as driven to the converters (10 bits per component)
  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
    logic blank_n;
    logic sync_n;
    logic [1:0] psel;
  } dac_word_t;

  // software controls of the block
  typedef struct packed {
    logic mux_rate_bit;
    logic [1:0] prg_div_sel;
    logic vsync_calibrate_enable;
    logic calibrate_step_one_bit;
    logic calibrate_step_two_bit;
    logic palette_resolution_bit;
    logic [3:0] color_mode_field;
  } ctrl_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_ARMED = 3'b010,
    CAL_ALIGN = 3'b100
  } cal_state_t;

endpackage

// ==== core/pixel_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module pixel_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ==== core/color_lut.sv ====
// three 256-entry component tables with registered read data
`timescale 1ns/10ps
module color_lut #(
  parameter int AW = 8,
  parameter int DW = 10
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [3*DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr_r,
  input wire logic [AW-1:0] rd_addr_g,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [3*DW-1:0] rd_data
);
  logic [DW-1:0] tab_r [2**AW];
  logic [DW-1:0] tab_g [2**AW];
  logic [DW-1:0] tab_b [2**AW];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      tab_r[wr_addr] <= wr_data[3*DW-1:2*DW];
      tab_g[wr_addr] <= wr_data[2*DW-1:DW];
      tab_b[wr_addr] <= wr_data[DW-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= {tab_r[rd_addr_r], tab_g[rd_addr_g], tab_b[rd_addr_b]};
  end
endmodule

// ==== core/pixel_clock_and_color_mode.sv ====
// pixel clock generation, calibration and colour mode table lookup
`timescale 1ns/10ps
// How it works
// R1: load clock toggles each pixel clock in 2:1, runs every pixel in 1:1; the code toggles it each pixel clock in 1:1 too.
// R2: the outside returns the load clock to the pixel latch input.
// R3: any load-to-latch delay is tolerated; latch edges are found, not timed.
// R4: programmable clock is pixel clock divided by 4, 8, 16 or 32.
// R5: programmable clock rises only together with a load clock rise.
// R6: gated shift clock is shift clock anded with the latched blanking.
// R7: when latch misses load timing, add 2 pixel stages in 2:1, 0 in 1:1.
// R8: calibration aligns latched pixel data with internal load phase.
// R9: host toggles calibrate step one then step two to calibrate.
// R10: with vsync calibrate enabled, calibrate at every vertical sync.
// R11: mode field bits one to three all set select true colour.
// R12: true colour gamma: each component indexes its own 10-bit table.
// R13: true colour standard: 8 bits per component, 24 bits out.
// R14: pseudo gamma: 8-bit index picks one 30-bit word.
// R15: pseudo standard: 8-bit index picks a word, 8 bits per component.
// R16: data, blanking, sync and selects are captured on latch rising edges.
// R17: pseudo index comes from red, green or blue; others ignored.
// R18: divisor change waits for a load-aligned wrap, no phase glitch.
module pixel_clock_and_color_mode
  import pixclk_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire pixclk_pkg::ctrl_t ctrl,
  input wire logic pixel_latch_in,
  input wire pixclk_pkg::pixel_word_t pixel_in,
  input wire logic shift_clock_in,
  input wire logic lut_wr_en,
  input wire logic [7:0] lut_wr_addr,
  input wire logic [29:0] lut_wr_data,
  input wire logic dac_ready,
  output logic load_clock_out,
  output logic programmable_clock_out,
  output logic gated_shift_clock_out,
  output pixclk_pkg::dac_word_t dac_out,
  output logic dac_valid,
  output logic calibrated,
  output logic fifo_overflow
);
  // pins from outside the clock domain, two flops each, plus a third on the latch for edge detect
  logic latch_s1_q;
  logic latch_s2_q;
  logic latch_s3_q;
  logic shift_s1_q;
  logic shift_s2_q;
  pixel_word_t pix_s1_q;
  pixel_word_t pix_s2_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch_s1_q <= 1'b0;
      latch_s2_q <= 1'b0;
      latch_s3_q <= 1'b0;
      shift_s1_q <= 1'b0;
      shift_s2_q <= 1'b0;
      pix_s1_q <= '0;
      pix_s2_q <= '0;
    end else begin
      latch_s1_q <= pixel_latch_in;
      latch_s2_q <= latch_s1_q;
      latch_s3_q <= latch_s2_q;
      shift_s1_q <= shift_clock_in;
      shift_s2_q <= shift_s1_q;
      pix_s1_q <= pixel_in;
      pix_s2_q <= pix_s1_q;
    end
  end

  // load phase runs in both modes so a mode change keeps the edges aligned
  logic load_phase_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      load_phase_q <= 1'b0;
    end else begin
      load_phase_q <= ~load_phase_q; // see R1
    end
  end

  // 1:1 cannot outrun the sample rate, so it shows as a toggle per pixel
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      load_clock_out <= 1'b0;
    end else if (ctrl.mux_rate_bit) begin
      load_clock_out <= ~load_phase_q; // see R1
    end else begin
      load_clock_out <= ~load_clock_out; // see R1
    end
  end

  // programmable clock divider, counted on pixel clocks
  logic [4:0] prg_cnt_q;
  logic [1:0] div_act_q;
  logic [4:0] div_mask;

  always_comb begin
    unique case (div_act_q)
      DIV_4: div_mask = 5'h03;
      DIV_8: div_mask = 5'h07;
      DIV_16: div_mask = 5'h0f;
      DIV_32: div_mask = 5'h1f;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prg_cnt_q <= PRG_CNT_RESET - 5'h01;
      div_act_q <= DIV_4;
      programmable_clock_out <= 1'b0;
    end else begin
      // reset sits at the wrap and periods are multiples of four, so every
      // wrap lands on a load clock rise
      if ((prg_cnt_q & div_mask) == div_mask) begin
        prg_cnt_q <= PRG_CNT_RESET;
        div_act_q <= ctrl.prg_div_sel; // see R18
      end else begin
        prg_cnt_q <= prg_cnt_q + 5'h01;
      end
      // high for the first half of the period, rises at count zero
      programmable_clock_out <=
        ((prg_cnt_q & div_mask) == div_mask) ? 1'b1 :
        (((prg_cnt_q + 5'h01) & div_mask) <= (div_mask >> 1)); // see R4 R5
    end
  end

  // latch edge detect on the synchronised returned clock
  logic latch_rise;
  assign latch_rise = latch_s2_q & ~latch_s3_q; // see R3 R16

  // calibration: sequence of step bits or vertical sync
  cal_state_t cal_q;
  logic step1_q;
  logic step2_q;
  logic sync_prev_q;
  logic vsync_fall;
  logic cal_go;
  logic vsync_go;
  logic latch_phase_q;
  logic late_q;

  assign vsync_fall = sync_prev_q & ~pix_s2_q.sync_n;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      step1_q <= 1'b0;
      step2_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      step1_q <= ctrl.calibrate_step_one_bit;
      step2_q <= ctrl.calibrate_step_two_bit;
      if (latch_rise) begin
        sync_prev_q <= pix_s2_q.sync_n;
      end
    end
  end

  assign cal_go =
    (cal_q == CAL_ARMED) && (step2_q != ctrl.calibrate_step_two_bit);
  assign vsync_go = ctrl.vsync_calibrate_enable && latch_rise && vsync_fall;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cal_q <= CAL_IDLE;
    end else begin
      unique case (cal_q)
        CAL_IDLE: begin
          if (step1_q != ctrl.calibrate_step_one_bit) begin
            cal_q <= CAL_ARMED; // see R9
          end else if (vsync_go) begin
            cal_q <= CAL_ALIGN; // see R10
          end
        end
        CAL_ARMED: begin
          if (cal_go || vsync_go) begin
            cal_q <= CAL_ALIGN; // see R9 R10
          end
        end
        CAL_ALIGN: begin
          if (latch_rise) begin
            cal_q <= CAL_IDLE; // see R8
          end
        end
        default: cal_q <= CAL_IDLE;
      endcase
    end
  end

  // record which load phase the returned latch lands on
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch_phase_q <= 1'b0;
      late_q <= 1'b0;
      calibrated <= 1'b0;
    end else if (cal_q == CAL_ALIGN && latch_rise) begin
      latch_phase_q <= load_phase_q; // see R8
      late_q <= load_phase_q != 1'b0; // see R7
      calibrated <= 1'b1;
    end else if (cal_q == CAL_ARMED) begin
      calibrated <= 1'b0;
    end
  end

  // capture pixel on latch edges; late phase adds extra stages in 2:1
  pixel_word_t cap_q;
  logic cap_v_q;
  pixel_word_t dly_q [EXTRA_LAT_2TO1];
  logic dly_v_q [EXTRA_LAT_2TO1];
  logic use_dly;

  assign use_dly = late_q && ctrl.mux_rate_bit && (EXTRA_LAT_2TO1 > 0);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cap_q <= '0;
      cap_v_q <= 1'b0;
    end else begin
      cap_v_q <= latch_rise; // see R3
      if (latch_rise) begin
        cap_q <= pix_s2_q; // see R16
      end
    end
  end

  genvar gi;
  for (gi = 0; gi < EXTRA_LAT_2TO1; gi++) begin : g_dly
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        dly_q[gi] <= '0;
        dly_v_q[gi] <= 1'b0;
      end else if (gi == 0) begin
        dly_q[gi] <= cap_q; // see R7
        dly_v_q[gi] <= cap_v_q;
      end else begin
        dly_q[gi] <= dly_q[(gi > 0) ? gi - 1 : 0];
        dly_v_q[gi] <= dly_v_q[(gi > 0) ? gi - 1 : 0];
      end
    end
  end

  pixel_word_t pipe_w;
  logic pipe_v;
  assign pipe_w = use_dly ? dly_q[EXTRA_LAT_2TO1-1] : cap_q;
  assign pipe_v = use_dly ? dly_v_q[EXTRA_LAT_2TO1-1] : cap_v_q;

  // fifo between capture and lookup; the lookup drains on dac_ready
  pixel_word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;

  pixel_fifo #(
    .WIDTH($bits(pixel_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_data(pipe_w),
    .in_valid(pipe_v),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // pixel stream cannot stall, so a full fifo loses pixels and says so
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fifo_overflow <= 1'b0;
    end else if (pipe_v && !fifo_in_ready) begin
      fifo_overflow <= 1'b1;
    end
  end

  // table address selection by colour mode
  logic true24;
  logic [1:0] chan;
  logic [7:0] idx;
  logic [7:0] addr_r;
  logic [7:0] addr_g;
  logic [7:0] addr_b;

  assign true24 =
    ctrl.color_mode_field[MODE_SEL_HI:MODE_SEL_LO] == MODE_TRUE24; // see R11
  assign chan = ctrl.color_mode_field[MODE_SEL_HI:MODE_SEL_HI-1];

  always_comb begin
    unique case (chan)
      PSEUDO_GREEN: idx = fifo_out.green; // see R17
      PSEUDO_BLUE: idx = fifo_out.blue; // see R17
      default: idx = fifo_out.red; // see R17
    endcase
  end

  // true colour: each component indexes its own table
  assign addr_r = true24 ? fifo_out.red : idx; // see R12 R14
  assign addr_g = true24 ? fifo_out.green : idx; // see R12 R14
  assign addr_b = true24 ? fifo_out.blue : idx; // see R12 R14

  assign fifo_pop = fifo_out_valid && dac_ready;

  logic [29:0] lut_q;
  color_lut #(
    .AW(LUT_AW),
    .DW(COMP_W)
  ) u_lut (
    .clk_sys(clk_sys),
    .wr_en(lut_wr_en),
    .wr_addr(lut_wr_addr),
    .wr_data(lut_wr_data),
    .rd_addr_r(addr_r),
    .rd_addr_g(addr_g),
    .rd_addr_b(addr_b),
    .rd_data(lut_q)
  );

  // controls travel one cycle alongside the table read
  pixel_word_t ctl_q;
  logic rd_v_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_q <= '0;
      rd_v_q <= 1'b0;
    end else begin
      ctl_q <= fifo_out;
      rd_v_q <= fifo_pop;
    end
  end

  // standard resolution keeps 8 bits per component, low bits zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dac_out <= '0;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= rd_v_q;
      if (rd_v_q) begin
        if (ctrl.palette_resolution_bit) begin
          dac_out.red <= lut_q[29:20]; // see R12 R14
          dac_out.green <= lut_q[19:10];
          dac_out.blue <= lut_q[9:0];
        end else begin
          dac_out.red <= {lut_q[29:22], 2'h0}; // see R13 R15
          dac_out.green <= {lut_q[19:12], 2'h0}; // see R13 R15
          dac_out.blue <= {lut_q[9:2], 2'h0}; // see R13 R15
        end
        dac_out.blank_n <= ctl_q.blank_n;
        dac_out.sync_n <= ctl_q.sync_n;
        dac_out.psel <= ctl_q.psel;
      end
    end
  end

  // shift clock gated by blanking latched on the pixel latch
  logic blank_lat_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      blank_lat_q <= 1'b0;
      gated_shift_clock_out <= 1'b0;
    end else begin
      if (latch_rise) begin
        blank_lat_q <= pix_s2_q.blank_n; // see R6
      end
      gated_shift_clock_out <= shift_s2_q & blank_lat_q; // see R6
    end
  end
endmodule

// ==== test/pixclk_props.sv ====
// port checks for the pixel clock and colour block
`timescale 1ns/10ps
module pixclk_props
  import pixclk_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire pixclk_pkg::ctrl_t ctrl,
  input wire logic shift_clock_in,
  input wire logic load_clock_out,
  input wire logic programmable_clock_out,
  input wire logic gated_shift_clock_out,
  input wire pixclk_pkg::dac_word_t dac_out,
  input wire logic dac_valid,
  input wire logic calibrated,
  input wire logic fifo_overflow
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  logic [5:0] per_q;
  logic [1:0] sel_q;
  logic [1:0] seld_q;
  logic seen_q;
  logic prg_q;
  logic [3:0] sck_q;
  logic s1_q;
  logic armed_q;
  // period counter; the first rise after reset only starts it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      per_q <= 6'h00;
      sel_q <= 2'h0;
      seld_q <= 2'h0;
      seen_q <= 1'b0;
      prg_q <= 1'b0;
    end else begin
      prg_q <= programmable_clock_out;
      // the divisor is taken at the wrap, one edge before the rise is seen
      seld_q <= ctrl.prg_div_sel;
      if (programmable_clock_out && !prg_q) begin
        per_q <= 6'h01;
        sel_q <= seld_q;
        seen_q <= 1'b1;
      end else if (per_q != 6'h3f) begin
        per_q <= per_q + 6'h01;
      end
    end
  end
  // recent shift clock samples cover the input synchroniser delay
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sck_q <= 4'h0;
      s1_q <= ctrl.calibrate_step_one_bit;
      armed_q <= 1'b0;
    end else begin
      sck_q <= {sck_q[2:0], shift_clock_in};
      s1_q <= ctrl.calibrate_step_one_bit;
      if (ctrl.calibrate_step_one_bit != s1_q) begin
        armed_q <= 1'b1;
      end else if (calibrated) begin
        armed_q <= 1'b0;
      end
    end
  end
  a_load_toggle: assert property (
    !$past(srst) && !$past(srst, 2) |->
      load_clock_out != $past(load_clock_out))
    else $error("load clock did not toggle");
  a_prg_align: assert property (
    $rose(programmable_clock_out) |-> $rose(load_clock_out))
    else $error("programmable clock rose off a load rise");
  a_prg_period: assert property (
    programmable_clock_out && !prg_q && seen_q |-> per_q == (6'h04 << sel_q))
    else $error("programmable clock period wrong");
  a_shift_gate: assert property (
    gated_shift_clock_out |-> sck_q != 4'h0)
    else $error("gated shift clock high without shift clock");
  a_dac_hold: assert property (
    !dac_valid |-> $stable(dac_out))
    else $error("converter word moved without valid");
  a_cal_clear: assert property (
    ctrl.calibrate_step_one_bit != s1_q |-> ##[1:3] !calibrated)
    else $error("calibrated not cleared when armed");
  a_cal_source: assert property (
    $rose(calibrated) |-> armed_q || ctrl.vsync_calibrate_enable)
    else $error("calibration finished without a request");
  a_overflow_hold: assert property (
    $past(fifo_overflow) |-> fifo_overflow)
    else $error("overflow flag dropped");
  a_reset_quiet: assert property (
    $past(srst) |-> !dac_valid && !calibrated && !fifo_overflow)
    else $error("outputs not quiet after reset");
endmodule

// ==== test/frame_buffer_model.sv ====
// frame buffer model: returns the load clock late and serves pixel words
`timescale 1ns/10ps
module frame_buffer_model
  import pixclk_pkg::*;
#(
  parameter int DELAY = 3
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load_clock_out,
  input wire pixclk_pkg::pixel_word_t next_word,
  output logic pixel_latch_in,
  output pixclk_pkg::pixel_word_t pixel_in,
  output logic shift_clock_in
);
  logic [DELAY-1:0] dly_q;
  // the delay is not a whole load period, so phase is arbitrary
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[DELAY-2:0], load_clock_out};
    end
  end
  assign pixel_latch_in = dly_q[DELAY-1];
  assign shift_clock_in = dly_q[0];
  // new word only as the latch falls, so it is settled at the next rise
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pixel_in <= '0;
    end else if (dly_q[DELAY-1] && !dly_q[DELAY-2]) begin
      pixel_in <= next_word;
    end
  end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the pixel clock and colour block
`timescale 1ns/10ps
module tb;
  import pixclk_pkg::*;
  logic clk_sys, srst, lut_wr_en, dac_ready, pixel_latch_in, shift_clock_in;
  logic load_clock_out, programmable_clock_out, gated_shift_clock_out;
  logic dac_valid, calibrated, fifo_overflow, acc;
  logic [7:0] lut_wr_addr;
  logic [29:0] lut_wr_data, la, lb, lc;
  ctrl_t ctrl;
  pixel_word_t next_word, pixel_in;
  dac_word_t dac_out;
  int bad_count = 0;
  int num_checks = 0;
  int n;
  localparam logic [29:0] STD = {10'h3fc, 10'h000, 10'h3fc};
  pixel_clock_and_color_mode pixel_clock_and_color_mode_inst (
    .clk_sys(clk_sys), .srst(srst), .ctrl(ctrl),
    .pixel_latch_in(pixel_latch_in), .pixel_in(pixel_in),
    .shift_clock_in(shift_clock_in), .lut_wr_en(lut_wr_en),
    .lut_wr_addr(lut_wr_addr), .lut_wr_data(lut_wr_data),
    .dac_ready(dac_ready), .load_clock_out(load_clock_out),
    .programmable_clock_out(programmable_clock_out),
    .gated_shift_clock_out(gated_shift_clock_out), .dac_out(dac_out),
    .dac_valid(dac_valid), .calibrated(calibrated),
    .fifo_overflow(fifo_overflow));
  frame_buffer_model #(.DELAY(3)) frame_buffer_model_inst (
    .clk_sys(clk_sys), .srst(srst), .load_clock_out(load_clock_out),
    .next_word(next_word), .pixel_latch_in(pixel_latch_in),
    .pixel_in(pixel_in), .shift_clock_in(shift_clock_in));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [29:0] lv(input logic [7:0] a);
    return {a, 2'h1, ~a, 2'h2, a ^ 8'h5a, 2'h3};
  endfunction
  function automatic pixel_word_t px(input logic [7:0] r, g, b);
    return {r, g, b, 1'b1, 1'b1, 2'h1};
  endfunction
  task automatic lut_wr(input logic [7:0] a, input logic [29:0] d);
    @(posedge clk_sys);
    lut_wr_en <= 1'b1;
    lut_wr_addr <= a;
    lut_wr_data <= d;
    @(posedge clk_sys);
    lut_wr_en <= 1'b0;
  endtask
  // stream one word until old pixels have drained, then take a pixel
  task automatic pix(input logic [3:0] m, input logic r, input pixel_word_t p,
      input logic [29:0] c);
    @(posedge clk_sys);
    ctrl.color_mode_field <= m;
    ctrl.palette_resolution_bit <= r;
    next_word <= p;
    tick(40);
    n = 0;
    while (dac_valid !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    check(dac_out, {c, 1'b1, 1'b1, 2'h1});
  endtask
  task automatic prg_rise();
    logic p;
    n = 0;
    p = programmable_clock_out;
    while (!(programmable_clock_out === 1'b1 && p === 1'b0) && n < 100) begin
      p = programmable_clock_out;
      tick(1);
      n++;
    end
  endtask
  task automatic wait_cal();
    n = 0;
    while (calibrated !== 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
  endtask
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
  initial begin
    srst = 1'b1;
    ctrl = '0;
    ctrl.mux_rate_bit = 1'b1;
    next_word = px(8'h00, 8'h00, 8'h00);
    lut_wr_en = 1'b0;
    lut_wr_addr = 8'h00;
    lut_wr_data = 30'h0;
    dac_ready = 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    lut_wr(8'h11, lv(8'h11));
    lut_wr(8'h22, lv(8'h22));
    lut_wr(8'h33, lv(8'h33));
    lut_wr(8'h44, {10'h3ff, 10'h000, 10'h3ff});
    la = lv(8'h11);
    lb = lv(8'h22);
    lc = lv(8'h33);
    for (int m = 1; m >= 0; m--) begin
      @(posedge clk_sys);
      ctrl.mux_rate_bit <= m[0];
      pix(4'he, 1'b1, px(8'h11, 8'h22, 8'h33),
          {la[29:20], lb[19:10], lc[9:0]});
      pix(4'he, 1'b0, px(8'h44, 8'h44, 8'h44), STD);
      pix(4'h2, 1'b1, px(8'h11, 8'h55, 8'h55), la);
      pix(4'h4, 1'b1, px(8'h55, 8'h22, 8'h55), lb);
      pix(4'h8, 1'b1, px(8'h55, 8'h55, 8'h33), lc);
      pix(4'h4, 1'b0, px(8'h55, 8'h44, 8'h55), STD);
    end
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_sys);
      next_word.blank_n <= b[0];
      tick(30);
      acc = 1'b0;
      repeat (16) begin
        tick(1);
        acc |= gated_shift_clock_out;
      end
      check({33'h0, acc}, {33'h0, b[0]});
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      ctrl.prg_div_sel <= s[1:0];
      tick(1);
      repeat (3) prg_rise();
      check(34'(n), 34'(4 << s));
    end
    @(posedge clk_sys);
    ctrl.calibrate_step_one_bit <= 1'b1;
    tick(4);
    check({33'h0, calibrated}, 34'h0);
    @(posedge clk_sys);
    ctrl.calibrate_step_two_bit <= 1'b1;
    wait_cal();
    check({33'h0, calibrated}, 34'h1);
    @(posedge clk_sys);
    ctrl.vsync_calibrate_enable <= 1'b1;
    ctrl.calibrate_step_one_bit <= 1'b0;
    tick(4);
    check({33'h0, calibrated}, 34'h0);
    @(posedge clk_sys);
    next_word.sync_n <= 1'b0;
    wait_cal();
    check({33'h0, calibrated}, 34'h1);
    check({33'h0, fifo_overflow}, 34'h0);
    // a stalled drain must fill the fifo and then lose pixels
    @(posedge clk_sys);
    dac_ready <= 1'b0;
    tick(100);
    check({33'h0, fifo_overflow}, 34'h1);
    @(posedge clk_sys);
    dac_ready <= 1'b1;
    tick(40);
    check({33'h0, fifo_overflow}, 34'h1);
    end_sim();
  end
endmodule
bind pixel_clock_and_color_mode pixclk_props pixclk_props_inst (
  .clk_sys(clk_sys), .srst(srst), .ctrl(ctrl),
  .shift_clock_in(shift_clock_in), .load_clock_out(load_clock_out),
  .programmable_clock_out(programmable_clock_out),
  .gated_shift_clock_out(gated_shift_clock_out), .dac_out(dac_out),
  .dac_valid(dac_valid), .calibrated(calibrated),
  .fifo_overflow(fifo_overflow));
